/* File: pslr_pkg.sv */
// pslr_pkg: constants and carrier types for the protection status and limit registers
// assumes a register access port supplied by the serial bus front end of the device
package pslr_pkg;
	// register indices on the device register port
	localparam logic [7:0] PSLR_ADDR_STATUS = 8'h00;
	localparam logic [7:0] PSLR_ADDR_LIMIT = 8'h01;
	// status flag positions
	localparam int PSLR_BIT_TEMP_WARN = 7;
	localparam int PSLR_BIT_PGOOD_WARN = 6;
	localparam int PSLR_BIT_TRACK = 5;
	localparam int PSLR_BIT_OVERTEMP = 4;
	localparam int PSLR_BIT_OVERCUR = 3;
	localparam int PSLR_BIT_UNDERV = 2;
	localparam int PSLR_BIT_OVERV = 1;
	localparam int PSLR_BIT_PHASEV = 0;
	// power-on values
	localparam logic [7:0] PSLR_STATUS_RESET = 8'hbf;
	localparam logic [2:0] PSLR_SLOPE_RESET = 3'h0;
	localparam logic PSLR_TCOMP_RESET = 1'b1;
	localparam logic [3:0] PSLR_LIMIT_RESET = 4'hb;
	// highest meaningful current-limit code (140 percent)
	localparam logic [3:0] PSLR_LIMIT_MAX = 4'hb;
	// configuration carried to the analog protection logic
	typedef struct packed {
		logic [2:0] load_regulation_slope;
		logic temp_compensation_enable;
		logic [3:0] current_limit_code;
	} pslr_limit_type;
	// register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pslr_req_type;
endpackage : pslr_pkg

/* File: pslr_regs.sv */
// pslr_regs: protection status register and current-limit setpoint register
// assumes the serial bus front end presents one-cycle read/write strobes on clk_i
// and that detector flags arrive asynchronously from the analog protection logic
//
// Operation
// - read-only 8-bit status register holds protection state
// - fixed flag positions, all power on 1 except power-good
// - bits 3:0 select overcurrent threshold percentage
// - limit codes above 0xb act as 0xb
// - bits 7:5 select load regulation slope
// - host may rewrite limits anytime; device applies them
`timescale 1ns/1ns
`default_nettype none
module pslr_regs
	import pslr_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire pslr_req_type req_i,
	input wire logic [7:0] flags_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	output pslr_limit_type limit_o
);
	logic [7:0] flags_meta;
	logic [7:0] flags_sync;
	logic [7:0] protection_status;
	pslr_limit_type current_limit_setpoint;
	logic [3:0] next_code;
	logic [7:0] next_status;

	// two-stage synchroniser for the detector flags
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			flags_meta <= PSLR_STATUS_RESET;
			flags_sync <= PSLR_STATUS_RESET;
		end
		else
		begin
			flags_meta <= flags_i;
			flags_sync <= flags_meta;
		end
	end

	// place each detector at its own status bit, so a swapped wire shows up here
	always_comb
	begin
		next_status = 8'h00;
		next_status[PSLR_BIT_TEMP_WARN] = flags_sync[PSLR_BIT_TEMP_WARN];
		next_status[PSLR_BIT_PGOOD_WARN] = flags_sync[PSLR_BIT_PGOOD_WARN];
		next_status[PSLR_BIT_TRACK] = flags_sync[PSLR_BIT_TRACK];
		next_status[PSLR_BIT_OVERTEMP] = flags_sync[PSLR_BIT_OVERTEMP];
		next_status[PSLR_BIT_OVERCUR] = flags_sync[PSLR_BIT_OVERCUR];
		next_status[PSLR_BIT_UNDERV] = flags_sync[PSLR_BIT_UNDERV];
		next_status[PSLR_BIT_OVERV] = flags_sync[PSLR_BIT_OVERV];
		next_status[PSLR_BIT_PHASEV] = flags_sync[PSLR_BIT_PHASEV];
	end

	// status mirrors the live protection state, writes never touch it
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			protection_status <= PSLR_STATUS_RESET;
		else
			protection_status <= next_status;
	end

	// saturate the limit code on write
	always_comb
	begin
		next_code = (req_i.wdata[3:0] > PSLR_LIMIT_MAX) ? PSLR_LIMIT_MAX : req_i.wdata[3:0];
	end

	// setpoint register, written at any time and applied immediately
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			current_limit_setpoint.load_regulation_slope <= PSLR_SLOPE_RESET;
			current_limit_setpoint.temp_compensation_enable <= PSLR_TCOMP_RESET;
			current_limit_setpoint.current_limit_code <= PSLR_LIMIT_RESET;
		end
		else if (req_i.wr && req_i.addr == PSLR_ADDR_LIMIT)
		begin
			current_limit_setpoint.load_regulation_slope <= req_i.wdata[7:5];
			current_limit_setpoint.temp_compensation_enable <= req_i.wdata[4];
			current_limit_setpoint.current_limit_code <= next_code;
		end
	end

	// configuration drives the protection logic from a flip-flop
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			limit_o <= {PSLR_SLOPE_RESET, PSLR_TCOMP_RESET, PSLR_LIMIT_RESET};
		else if (req_i.wr && req_i.addr == PSLR_ADDR_LIMIT)
			limit_o <= {req_i.wdata[7:5], req_i.wdata[4], next_code};
	end

	// read port: data one cycle after the strobe, unmapped reads give zero
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			rdata_o <= 8'h00;
			rvalid_o <= 1'b0;
		end
		else
		begin
			rvalid_o <= req_i.rd;
			if (req_i.rd)
			begin
				unique case (req_i.addr)
					PSLR_ADDR_STATUS: rdata_o <= protection_status;
					PSLR_ADDR_LIMIT: rdata_o <= current_limit_setpoint;
					default: rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// checks on the reset values
	status_rst_a: assert property (@(posedge clk_i) sys_rst_i
		|=> protection_status == PSLR_STATUS_RESET)
		else $error("status power-on value wrong");

	// power-good is the one flag that powers on clear
	pgood_rst_a: assert property (@(posedge clk_i) sys_rst_i
		|=> !protection_status[PSLR_BIT_PGOOD_WARN] && protection_status[PSLR_BIT_TEMP_WARN])
		else $error("power-good power-on value wrong");

	// setpoint powers on with slope 0, compensation on and the top limit code
	limit_rst_a: assert property (@(posedge clk_i) sys_rst_i
		|=> limit_o == {PSLR_SLOPE_RESET, PSLR_TCOMP_RESET, PSLR_LIMIT_RESET})
		else $error("setpoint power-on value wrong");

	// the read port comes out of reset idle and cleared
	rdport_rst_a: assert property (@(posedge clk_i) sys_rst_i
		|=> !rvalid_o && rdata_o == 8'h00)
		else $error("read port power-on value wrong");

	// status follows the detectors three edges late once the whole pipe has refilled
	status_ro_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!$past(sys_rst_i) && !$past(sys_rst_i, 2) && !$past(sys_rst_i, 3)
		|-> protection_status == $past(flags_i, 3))
		else $error("status does not follow detectors");

	// a write to the status index leaves the register to the detectors
	status_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		req_i.wr && req_i.addr == PSLR_ADDR_STATUS
		|=> protection_status == $past(next_status))
		else $error("status changed by a write");

	// a status read answers with the register as it stood at the strobe
	status_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		req_i.rd && req_i.addr == PSLR_ADDR_STATUS
		|=> rvalid_o && rdata_o == $past(protection_status))
		else $error("status read back mismatch");

	// reads of unmapped indices answer with zero
	unmapped_rd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		req_i.rd && req_i.addr != PSLR_ADDR_STATUS && req_i.addr != PSLR_ADDR_LIMIT
		|=> rvalid_o && rdata_o == 8'h00)
		else $error("unmapped read not zero");

	// the answer strobe lasts one cycle and the data holds until the next read
	rvalid_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!req_i.rd |=> !rvalid_o && $stable(rdata_o))
		else $error("read answer without strobe");

	// the stored code never exceeds the saturation code
	code_sat_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		limit_o.current_limit_code <= PSLR_LIMIT_MAX)
		else $error("limit code above saturation");

	// a code written above the top is stored as the top
	code_clip_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		req_i.wr && req_i.addr == PSLR_ADDR_LIMIT && req_i.wdata[3:0] > PSLR_LIMIT_MAX
		|=> limit_o.current_limit_code == PSLR_LIMIT_MAX)
		else $error("limit code not saturated");

	// a code in range is stored as written
	code_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		req_i.wr && req_i.addr == PSLR_ADDR_LIMIT && req_i.wdata[3:0] <= PSLR_LIMIT_MAX
		|=> limit_o.current_limit_code == $past(req_i.wdata[3:0]))
		else $error("limit code not applied");

	// slope field lands in bits 7:5
	slope_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		req_i.wr && req_i.addr == PSLR_ADDR_LIMIT
		|=> limit_o.load_regulation_slope == $past(req_i.wdata[7:5]))
		else $error("slope not applied");

	// compensation enable lands in bit 4
	tcomp_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		req_i.wr && req_i.addr == PSLR_ADDR_LIMIT
		|=> limit_o.temp_compensation_enable == $past(req_i.wdata[4]))
		else $error("temperature compensation not applied");

	// the setpoint changes only on a write to its own index
	limit_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!(req_i.wr && req_i.addr == PSLR_ADDR_LIMIT) |=> $stable(limit_o))
		else $error("limit changed without write");

	// the setpoint reads back as it is applied
	read_back_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		req_i.rd && req_i.addr == PSLR_ADDR_LIMIT |=> rvalid_o && rdata_o == limit_o)
		else $error("limit read back mismatch");

	// a code above the top is written
	sat_write_c: cover property (@(posedge clk_i)
		req_i.wr && req_i.addr == PSLR_ADDR_LIMIT && req_i.wdata[3:0] > PSLR_LIMIT_MAX);
	// the host reads the status
	status_read_c: cover property (@(posedge clk_i) req_i.rd && req_i.addr == PSLR_ADDR_STATUS);
	// the host tries to write the status
	status_write_c: cover property (@(posedge clk_i) req_i.wr && req_i.addr == PSLR_ADDR_STATUS);
	// the host reads past the mapped indices
	unmapped_read_c: cover property (@(posedge clk_i) req_i.rd && req_i.addr > PSLR_ADDR_LIMIT);
	// a detector leaves its power-on state
	fault_seen_c: cover property (@(posedge clk_i) protection_status != PSLR_STATUS_RESET);
endmodule : pslr_regs
`default_nettype wire

/* File: pslr_host.sv */
// pslr_host: bus host model issuing register requests
// assumes strobes are taken on rising edges of clk_i
`timescale 1ns/1ns
`default_nettype none
module pslr_host
	import pslr_pkg::*;
(
	input wire logic clk_i,
	output pslr_req_type req_o
);
	initial req_o = '0;
	// one-cycle strobe, released lines show the inverse
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
	begin
		@(posedge clk_i);
		#2 req_o = {w, ~w, a, d};
		@(posedge clk_i);
		#2 req_o = {2'b00, ~a, ~d};
	end
	endtask : xfer
endmodule : pslr_host
`default_nettype wire

/* File: test_pslr_regs.sv */
// test_pslr_regs: self-checking bench for the register slice
// assumes one clock and the host model driving requests
`timescale 1ns/1ns
`default_nettype none
module test_pslr_regs
	import pslr_pkg::*;
;
	logic clk_i = 0, sys_rst_i = 1, rvalid_o;
	logic [7:0] flags_i = 0, rdata_o, v, e;
	pslr_limit_type limit_o;
	pslr_req_type req;
	int num_errors = 0, n_tests = 0, seed = 5, cyc = 0;
	logic [7:0] expq[$];
	pslr_host host(.clk_i(clk_i), .req_o(req));
	pslr_regs dut(.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req), .flags_i(flags_i),
		.rdata_o(rdata_o), .rvalid_o(rvalid_o), .limit_o(limit_o));
	initial forever #25 clk_i = ~clk_i;
	task automatic check(input string n, input logic [7:0] x, input logic [7:0] y);
	begin
		n_tests++;
		if (x !== y)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, x, y);
		end
	end
	endtask : check
	// note the expected answer, then issue the read
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
	begin
		expq.push_back(x);
		host.xfer(1'b0, a, 8'h00);
	end
	endtask : rd
	task automatic report_and_stop;
	begin
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask : report_and_stop
	// read answer monitor and hang limit
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc > 2000)
		begin
			num_errors++;
			report_and_stop();
		end
		if (rvalid_o === 1'b1)
			check("rdata", expq.size() ? expq.pop_front() : 8'hxx, rdata_o);
	end
	// main sequence
	initial
	begin
		repeat (10) @(posedge clk_i);
		#2 sys_rst_i = 0;
		rd(PSLR_ADDR_STATUS, PSLR_STATUS_RESET);
		rd(PSLR_ADDR_LIMIT, 8'h1b);
		for (int i = 0; i < 16; i++)
		begin
			v = 8'($random(seed));
			v[3:0] = 4'(i);
			e = {v[7:4], (v[3:0] > PSLR_LIMIT_MAX) ? PSLR_LIMIT_MAX : v[3:0]};
			host.xfer(1'b1, PSLR_ADDR_LIMIT, v);
			check("limit", e, limit_o);
			rd(PSLR_ADDR_LIMIT, e);
		end
		$display("test limit codes done");
		// reset again in mid-run: the power-on values must come back
		@(posedge clk_i);
		#2 sys_rst_i = 1;
		repeat (2) @(posedge clk_i);
		#2 sys_rst_i = 0;
		e = 8'h1b;
		check("limit", e, limit_o);
		rd(PSLR_ADDR_STATUS, PSLR_STATUS_RESET);
		rd(PSLR_ADDR_LIMIT, e);
		$display("test reset done");
		for (int i = 0; i < 6; i++)
		begin
			flags_i = 8'($random(seed));
			host.xfer(1'b1, PSLR_ADDR_STATUS, ~flags_i);
			repeat (3) @(posedge clk_i);
			rd(PSLR_ADDR_STATUS, flags_i);
		end
		$display("test status done");
		host.xfer(1'b1, 8'h07, 8'h00);
		check("limit", e, limit_o);
		rd(8'h07, 8'h00);
		repeat (3) @(posedge clk_i);
		check("pending", 8'h00, 8'(expq.size()));
		$display("test unmapped done");
		report_and_stop();
	end
endmodule : test_pslr_regs
`default_nettype wire
